// file: inc/pmr_defines.vh
`ifndef PMR_DEFINES_VH
`define PMR_DEFINES_VH

`define PMR_ADDR_STATUS     5'h01
`define PMR_ADDR_IDENT_HI   5'h02
`define PMR_ADDR_IDENT_LO   5'h03
`define PMR_ADDR_ADVERTISE  5'h04
`define PMR_ADDR_PARTNER    5'h05
`define PMR_ADDR_EXPANSION  5'h06
`define PMR_ADDR_RSVD_LO    5'h08
`define PMR_ADDR_RSVD_HI    5'h0f

`define PMR_STS_ABILITY     4'hf
`define PMR_ADV_FAULT_BIT   13
`define PMR_ADV_TECH_RESET  8'h2f
`define PMR_ADV_SELECTOR    5'h01
`define PMR_ADV_SEL_HI      4
`define PMR_ADV_TECH_HI     12
`define PMR_ADV_TECH_LO     5
`define PMR_STS_ABILITY_HI  14
`define PMR_STS_ABILITY_LO  11
`define PMR_STS_NO_PREAMBLE 6
`define PMR_STS_AN_DONE     5
`define PMR_STS_RFAULT      4
`define PMR_STS_AN_ABLE     3
`define PMR_STS_LINK        2
`define PMR_STS_JABBER      1
`define PMR_STS_EXTENDED    0
`define PMR_PART_ACK_BIT    14
`define PMR_EXP_PD_FAULT    4
`define PMR_EXP_PART_NP     3
`define PMR_EXP_LOCAL_NP    2
`define PMR_EXP_PAGE_RX     1
`define PMR_EXP_PART_AN     0
`define PMR_IDENT_HI_VALUE  16'h1234 // Arbitrary identifier value
`define PMR_IDENT_LO_VALUE  16'h5678 // Arbitrary identifier value

`endif

// file: rtl/pmr_latch_bit.v
`timescale 1ns/1ps
module pmr_latch_bit #(
  parameter LATCH_HIGH = 1
) (
  ref_clk,
  reset,
  event_in,
  read_clear,
  value
);
  input  wire ref_clk;
  input  wire reset;
  input  wire event_in;
  input  wire read_clear;
  output wire value;

  reg latch_q;
  reg latch_d;

  // Latch-low bits store the loss and show its inverse, so they wake up reading zero
  localparam [0:0] INVERT = (LATCH_HIGH == 0) ? 1'b1 : 1'b0;

  // Event wins over the read that clears it, so nothing is lost
  always @* begin
    latch_d = latch_q;
    if (read_clear) begin
      latch_d = 1'b0;
    end
    if (event_in) begin
      latch_d = 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      latch_q <= INVERT;
    end else begin
      latch_q <= latch_d;
    end
  end

  assign value = latch_q ^ INVERT;
endmodule // pmr_latch_bit

// file: rtl/pmr_regs.v
`timescale 1ns/1ps
`include "pmr_defines.vh"
module pmr_regs (
  ref_clk,
  reset,
  mgmt_addr,
  mgmt_wr,
  mgmt_rd,
  mgmt_wdata,
  mgmt_rdata,
  an_complete,
  link_up,
  jabber_event,
  partner_word,
  partner_ack,
  parallel_fault_event,
  page_rx_event,
  partner_np_able,
  partner_an_able,
  adv_word
);
  input  wire        ref_clk;
  input  wire        reset;
  input  wire [4:0]  mgmt_addr;
  input  wire        mgmt_wr;
  input  wire        mgmt_rd;
  input  wire [15:0] mgmt_wdata;
  output wire [15:0] mgmt_rdata;
  input  wire        an_complete;
  input  wire        link_up;
  input  wire        jabber_event;
  input  wire [15:0] partner_word;
  input  wire        partner_ack;
  input  wire        parallel_fault_event;
  input  wire        page_rx_event;
  input  wire        partner_np_able;
  input  wire        partner_an_able;
  output wire [15:0] adv_word;

  ////////////////////////////////////////////////////////////////////////
  // Status inputs arrive from the negotiation and link logic on ref_clk,
  // so they need no synchroniser

  reg        adv_fault_q;
  reg        adv_fault_d;
  reg [7:0]  adv_tech_q;
  reg [7:0]  adv_tech_d;
  reg        an_done_q;
  reg [15:0] partner_q;
  reg        partner_ack_q;
  reg        np_able_q;
  reg        an_able_q;
  reg [15:0] rdata_q;
  reg [15:0] rdata_d;
  wire       link_lost;
  wire       link_bit;
  wire       jabber_bit;
  wire       pd_fault_bit;
  wire       page_bit;
  wire       rd_status;
  wire       rd_expand;
  wire       wr_adv;
  wire       rsvd_hit;

  ////////////////////////////////////////////////////////////////////////
  // Helper functions

  function addr_hit;
    input [4:0] addr;
    input [4:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  function addr_reserved;
    input [4:0] addr;
    begin
      addr_reserved = (addr >= `PMR_ADDR_RSVD_LO) && (addr <= `PMR_ADDR_RSVD_HI);
    end
  endfunction

  function [15:0] status_word;
    input an_done;
    input link_ok;
    input jabber;
    begin
      status_word                                           = 16'h0000;
      status_word[`PMR_STS_ABILITY_HI:`PMR_STS_ABILITY_LO] = `PMR_STS_ABILITY;
      status_word[`PMR_STS_NO_PREAMBLE]                    = 1'b0;
      status_word[`PMR_STS_AN_DONE]                        = an_done;
      status_word[`PMR_STS_RFAULT]                         = 1'b0;
      status_word[`PMR_STS_AN_ABLE]                        = 1'b1;
      status_word[`PMR_STS_LINK]                           = link_ok;
      status_word[`PMR_STS_JABBER]                         = jabber;
      status_word[`PMR_STS_EXTENDED]                       = 1'b1;
    end
  endfunction

  function [15:0] expansion_word;
    input pd_fault;
    input part_np;
    input page_rx;
    input part_an;
    begin
      expansion_word                    = 16'h0000;
      expansion_word[`PMR_EXP_PD_FAULT] = pd_fault;
      expansion_word[`PMR_EXP_PART_NP]  = part_np;
      expansion_word[`PMR_EXP_LOCAL_NP] = 1'b0;
      expansion_word[`PMR_EXP_PAGE_RX]  = page_rx;
      expansion_word[`PMR_EXP_PART_AN]  = part_an;
    end
  endfunction

  function [15:0] partner_view;
    input [15:0] word;
    input        ack;
    begin
      partner_view                    = word;
      partner_view[`PMR_PART_ACK_BIT] = ack;
    end
  endfunction

  function [15:0] advert_word;
    input       fault;
    input [7:0] tech;
    begin
      advert_word                                    = 16'h0000;
      advert_word[`PMR_ADV_FAULT_BIT]                = fault;
      advert_word[`PMR_ADV_TECH_HI:`PMR_ADV_TECH_LO] = tech;
      advert_word[`PMR_ADV_SEL_HI:0]                 = `PMR_ADV_SELECTOR;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Strobe decode; a strobe held two edges would clear latched bits twice

  assign rd_status = mgmt_rd && addr_hit(mgmt_addr, `PMR_ADDR_STATUS);
  assign rd_expand = mgmt_rd && addr_hit(mgmt_addr, `PMR_ADDR_EXPANSION);
  assign wr_adv    = mgmt_wr && addr_hit(mgmt_addr, `PMR_ADDR_ADVERTISE);
  assign rsvd_hit  = addr_reserved(mgmt_addr);

  ////////////////////////////////////////////////////////////////////////
  // Writable advertisement fields

  always @* begin
    adv_fault_d = adv_fault_q;
    adv_tech_d  = adv_tech_q;
    if (wr_adv) begin
      adv_fault_d = mgmt_wdata[`PMR_ADV_FAULT_BIT];
      adv_tech_d  = mgmt_wdata[`PMR_ADV_TECH_HI:`PMR_ADV_TECH_LO];
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      adv_fault_q <= 1'b0;
      adv_tech_q  <= `PMR_ADV_TECH_RESET;
    end else begin
      adv_fault_q <= adv_fault_d;
      adv_tech_q  <= adv_tech_d;
    end
  end

  // Next page and reserved stay zero, selector fixed
  assign adv_word = advert_word(adv_fault_q, adv_tech_q);

  ////////////////////////////////////////////////////////////////////////
  // Tracked status, one register stage behind the negotiation logic

  // Completion is not latched, so a restarted negotiation shows at once
  always @(posedge ref_clk) begin
    if (reset) begin
      an_done_q <= 1'b0;
    end else begin
      an_done_q <= an_complete;
    end
  end

  // The word is taken whole each cycle; the negotiation logic updates it at once
  always @(posedge ref_clk) begin
    if (reset) begin
      partner_q     <= 16'h0000;
      partner_ack_q <= 1'b0;
    end else begin
      partner_q     <= partner_word;
      partner_ack_q <= partner_ack;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      np_able_q <= 1'b0;
      an_able_q <= 1'b0;
    end else begin
      np_able_q <= partner_np_able;
      an_able_q <= partner_an_able;
    end
  end

  // A read returns the held loss, so software reads twice to see the present link
  assign link_lost = ~link_up;

  pmr_latch_bit #(.LATCH_HIGH(0)) u_link (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .event_in   (link_lost),
    .read_clear (rd_status),
    .value      (link_bit)
  );

  pmr_latch_bit #(.LATCH_HIGH(1)) u_jabber (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .event_in   (jabber_event),
    .read_clear (rd_status),
    .value      (jabber_bit)
  );

  pmr_latch_bit #(.LATCH_HIGH(1)) u_pd_fault (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .event_in   (parallel_fault_event),
    .read_clear (rd_expand),
    .value      (pd_fault_bit)
  );

  pmr_latch_bit #(.LATCH_HIGH(1)) u_page_rx (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .event_in   (page_rx_event),
    .read_clear (rd_expand),
    .value      (page_bit)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read data, registered; writes to read-only words are never decoded

  // Held between reads so a slow sampler still sees the word
  always @* begin
    rdata_d = rdata_q;
    if (mgmt_rd) begin
      if (rsvd_hit) begin
        rdata_d = 16'h0000;
      end else begin
        case (mgmt_addr)
          `PMR_ADDR_STATUS: begin
            rdata_d = status_word(an_done_q, link_bit, jabber_bit);
          end
          `PMR_ADDR_IDENT_HI: begin
            rdata_d = `PMR_IDENT_HI_VALUE;
          end
          `PMR_ADDR_IDENT_LO: begin
            rdata_d = `PMR_IDENT_LO_VALUE;
          end
          `PMR_ADDR_ADVERTISE: begin
            rdata_d = adv_word;
          end
          `PMR_ADDR_PARTNER: begin
            rdata_d = partner_view(partner_q, partner_ack_q);
          end
          `PMR_ADDR_EXPANSION: begin
            rdata_d = expansion_word(pd_fault_bit, np_able_q, page_bit, an_able_q);
          end
          default: begin
            // Control word and vendor space live outside this block
            rdata_d = 16'h0000;
          end
        endcase
      end
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign mgmt_rdata = rdata_q;
endmodule // pmr_regs

// file: test/pmr_mac.sv
`timescale 1ns/1ps
module pmr_mac (
  input  wire        ref_clk,
  input  wire [15:0] mgmt_rdata,
  output reg  [4:0]  mgmt_addr = 5'h00,
  output reg         mgmt_wr = 1'h0,
  output reg         mgmt_rd = 1'h0,
  output reg  [15:0] mgmt_wdata = 16'h0000
);
  // Entered at a falling edge; one strobe edge, then one idle cycle
  task xfer(input wr, input [4:0] a, input [15:0] d, output [15:0] q);
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = wr;
    mgmt_rd = !wr;
    @(negedge ref_clk);
    mgmt_wr = 1'h0;
    mgmt_rd = 1'h0;
    // Released lines flip so a stale value never looks valid
    mgmt_addr = ~a;
    mgmt_wdata = ~d;
    @(negedge ref_clk);
    q = mgmt_rdata;
  endtask
endmodule // pmr_mac

// file: test/pmr_properties.sv
`timescale 1ns/1ps
`include "pmr_defines.vh"
module pmr_properties (
  input wire        ref_clk,
  input wire        reset,
  input wire [4:0]  mgmt_addr,
  input wire        mgmt_wr,
  input wire        mgmt_rd,
  input wire [15:0] mgmt_wdata,
  input wire [15:0] mgmt_rdata,
  input wire [15:0] adv_word,
  input wire        link_up,
  input wire        jabber_event
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire rs = mgmt_rd && mgmt_addr == 5'h01;
  property p_sts;
    rs |=> mgmt_rdata[15:6] == 10'h1e0 && mgmt_rdata[4:3] == 2'h1 && mgmt_rdata[0];
  endproperty
  a_sts: assert property (p_sts) else $error("status constants wrong");
  property p_id;
    mgmt_rd && mgmt_addr == 5'h02 |=> mgmt_rdata == `PMR_IDENT_HI_VALUE;
  endproperty
  a_id: assert property (p_id) else $error("ident wrong");
  property p_adv;
    adv_word[15:14] == 2'h0 && adv_word[4:0] == `PMR_ADV_SELECTOR;
  endproperty
  a_adv: assert property (p_adv) else $error("advert fixed bits wrong");
  wire [8:0] wr_field = mgmt_wdata[13:5];
  property p_wr;
    mgmt_wr && mgmt_addr == 5'h04 |=> adv_word[13:5] == $past(wr_field);
  endproperty
  a_wr: assert property (p_wr) else $error("advert write lost");
  property p_rsv;
    mgmt_rd && mgmt_addr[4:3] == 2'h1 |=> mgmt_rdata == 16'h0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved read not zero");
  property p_exp;
    mgmt_rd && mgmt_addr == 5'h06 |=> mgmt_rdata[15:5] == 11'h000 && !mgmt_rdata[2];
  endproperty
  a_exp: assert property (p_exp) else $error("expansion zero bits set");
  property p_lnk;
    !link_up ##1 rs |=> !mgmt_rdata[2];
  endproperty
  a_lnk: assert property (p_lnk) else $error("link loss not latched");
  property p_jab;
    jabber_event ##1 rs |=> mgmt_rdata[1];
  endproperty
  a_jab: assert property (p_jab) else $error("jabber not latched");
  c_lnk: cover property (rs ##1 mgmt_rdata[2]);
  c_jab: cover property (jabber_event ##1 rs);
  c_wr: cover property (mgmt_wr && mgmt_addr == 5'h04);
endmodule // pmr_properties
bind pmr_regs pmr_properties chk_u (.ref_clk(ref_clk), .reset(reset), .mgmt_addr(mgmt_addr),
  .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
  .adv_word(adv_word), .link_up(link_up), .jabber_event(jabber_event));

// file: test/pmr_regs_tb.sv
`timescale 1ns/1ps
`include "pmr_defines.vh"
module pmr_regs_tb;
  reg  ref_clk = 1'h0, reset = 1'h1, an_complete = 1'h0, link_up = 1'h0, jabber_event = 1'h0;
  reg  partner_ack = 1'h0, parallel_fault_event = 1'h0, page_rx_event = 1'h0;
  reg  partner_np_able = 1'h0, partner_an_able = 1'h0;
  reg  [15:0] partner_word = 16'h0000, q, w;
  wire [15:0] mgmt_wdata, mgmt_rdata, adv_word;
  wire [4:0]  mgmt_addr;
  wire        mgmt_wr, mgmt_rd;
  integer     err_total = 0, cmp_count = 0, cyc = 0, i;
  pmr_mac mac_u (.ref_clk(ref_clk), .mgmt_rdata(mgmt_rdata), .mgmt_addr(mgmt_addr),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata));
  pmr_regs dut_u (.ref_clk(ref_clk), .reset(reset), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
    .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .an_complete(an_complete), .link_up(link_up), .jabber_event(jabber_event),
    .partner_word(partner_word), .partner_ack(partner_ack),
    .parallel_fault_event(parallel_fault_event), .page_rx_event(page_rx_event),
    .partner_np_able(partner_np_able), .partner_an_able(partner_an_able), .adv_word(adv_word));
  initial forever #10 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  function [15:0] sts(input l, input j, input an);
    sts = {1'h0, 4'hf, 5'h00, an, 2'h1, l, j, 1'h1};
  endfunction
  function [15:0] adv(input [15:0] v);
    adv = {2'h0, v[13:5], `PMR_ADV_SELECTOR};
  endfunction
  task chk(input [15:0] seen, input [15:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task rd(input [4:0] a, input [15:0] exp);
    mac_u.xfer(1'h0, a, 16'h0000, q);
    chk(q, exp);
  endtask
  task stop_test;
    $display("errors=%0d compares=%0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Bounded run so a hung handshake still reaches the report
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 1000) begin
      err_total = err_total + 1;
      stop_test;
    end
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'hbaac162f));
    repeat (2) @(negedge ref_clk);
    reset = 1'h0;
    rd(5'h01, sts(0, 0, 0));
    mac_u.xfer(1'h1, 5'h02, 16'h0000, q);
    rd(5'h02, `PMR_IDENT_HI_VALUE);
    rd(5'h03, `PMR_IDENT_LO_VALUE);
    rd(5'h04, 16'h05e1);
    for (i = 0; i < 8; i = i + 1) begin
      w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : $urandom;
      mac_u.xfer(1'h1, 5'h04, w, q);
      chk(adv_word, adv(w));
      rd(5'h04, adv(w));
    end
    for (i = 7; i < 16; i = i + 1) begin
      mac_u.xfer(1'h1, i[4:0], 16'hffff, q);
      rd(i[4:0], 16'h0000);
    end
    rd(5'h04, adv(w));
    an_complete = 1'h1;
    link_up = 1'h1;
    @(negedge ref_clk);
    rd(5'h01, sts(0, 0, 1));
    rd(5'h01, sts(1, 0, 1));
    link_up = 1'h0;
    jabber_event = 1'h1;
    @(negedge ref_clk);
    link_up = 1'h1;
    jabber_event = 1'h0;
    rd(5'h01, sts(0, 1, 1));
    rd(5'h01, sts(1, 0, 1));
    w = $urandom;
    partner_word = w;
    {partner_ack, partner_np_able, partner_an_able} = 3'h7;
    {parallel_fault_event, page_rx_event} = 2'h3;
    @(negedge ref_clk);
    {parallel_fault_event, page_rx_event} = 2'h0;
    rd(5'h05, {w[15], 1'h1, w[13:0]});
    rd(5'h06, 16'h001b);
    rd(5'h06, 16'h0009);
    w = $urandom;
    partner_word = w;
    {partner_ack, partner_np_able, partner_an_able} = 3'h0;
    mac_u.xfer(1'h1, 5'h06, 16'hffff, q);
    rd(5'h05, {w[15], 1'h0, w[13:0]});
    rd(5'h06, 16'h0000);
    mac_u.xfer(1'h1, 5'h01, 16'h0000, q);
    rd(5'h01, sts(1, 0, 1));
    jabber_event = 1'h1;
    reset = 1'h1;
    repeat (2) @(negedge ref_clk);
    {jabber_event, reset} = 2'h0;
    rd(5'h01, sts(0, 0, 0));
    rd(5'h04, 16'h05e1);
    stop_test;
  end
endmodule // pmr_regs_tb
